// File: core/even_halfword_mac_unit.sv
/*
 * even half-word multiply datapath with 64-bit accumulator: guarded
 * 64-bit accumulate forms, plain fractional multiply, word accumulate.
 * assumes the pipeline presents one instruction per valid cycle with
 * both source registers; result appears one clock later.
 */
// Function
// - guarded signed fractional accumulate adds the extended low product to acc.
// - guarded sums wrap modulo 2^64 and touch no status register.
// - guarded signed fractional negative subtracts the low product from acc.
// - guarded differences wrap modulo 2^64 and touch no status register.
// - guarded signed integer accumulate adds the sign-extended low product.
// - guarded signed integer negative subtracts the sign-extended low product.
// - guarded unsigned accumulate adds the zero-extended low product.
// - guarded unsigned negative subtracts the zero-extended low product.
// - plain fractional multiply puts both even-lane products in the two words.
// - the accumulate-select bit copies the result to acc, else acc holds.
// - word accumulate adds each fractional product to its acc word mod 2^32.
// - word negative subtracts each fractional product from its acc word.
`default_nettype none
module even_halfword_mac_unit
    import mac_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rstn_in,
    // issue
    input wire logic issue_valid_in,
    input wire logic [31:0] insn_in,
    input wire logic [63:0] source_reg_a_in,
    input wire logic [63:0] source_reg_b_in,
    // result
    output logic result_valid_out,
    output logic [63:0] result_out,
    output logic [63:0] mac_accumulator_out,
    output logic illegal_out
);
    // ************************************************************
    // decode
    // ************************************************************
    mac_issue_if mi ();
    mac_op_t op;
    logic [5:0] prim;
    logic [10:0] ext;
    logic prim_hit;
    logic acc_sel;
    assign prim = insn_in[PRIM_HI:PRIM_LO];
    assign ext = insn_in[EXT_HI:EXT_LO];
    assign prim_hit = (prim == PRIM_VEC);
    assign acc_sel = insn_in[ACC_SEL_POS];
    assign op = !prim_hit ? OP_NONE :
        (ext == EXT_GSMFAA) ? OP_GSMFAA :
        (ext == EXT_GSMFAN) ? OP_GSMFAN :
        (ext == EXT_GSMIAA) ? OP_GSMIAA :
        (ext == EXT_GSMIAN) ? OP_GSMIAN :
        (ext == EXT_GUMIAA) ? OP_GUMIAA :
        (ext == EXT_GUMIAN) ? OP_GUMIAN :
        ((ext & EXT_SMF_MASK) == EXT_SMF) ? OP_SMF :
        (ext == EXT_SMFAAW) ? OP_SMFAAW :
        (ext == EXT_SMFANW) ? OP_SMFANW : OP_NONE;
    // ************************************************************
    // multipliers
    // ************************************************************
    assign mi.a_hi = source_reg_a_in[HI_EVEN_LO +: HALF_W];
    assign mi.b_hi = source_reg_b_in[HI_EVEN_LO +: HALF_W];
    assign mi.a_lo = source_reg_a_in[LO_EVEN_LO +: HALF_W];
    assign mi.b_lo = source_reg_b_in[LO_EVEN_LO +: HALF_W];
    halfword_mult u_mult (
        .m(mi)
    );
    // ************************************************************
    // arithmetic
    // ************************************************************
    logic [63:0] acc;
    logic [63:0] sf_ext;
    logic [63:0] si_ext;
    logic [63:0] ui_ext;
    logic [63:0] g_sf_add;
    logic [63:0] g_sf_sub;
    logic [63:0] g_si_add;
    logic [63:0] g_si_sub;
    logic [63:0] g_ui_add;
    logic [63:0] g_ui_sub;
    logic [63:0] plain_smf;
    logic [31:0] w_hi_add;
    logic [31:0] w_lo_add;
    logic [31:0] w_hi_sub;
    logic [31:0] w_lo_sub;
    assign sf_ext = {{32{mi.sf_lo[31]}}, mi.sf_lo};
    assign si_ext = {{32{mi.si_lo[31]}}, mi.si_lo};
    assign ui_ext = {32'h0000_0000, mi.ui_lo};
    // 64-bit adders drop the carry: no overflow flag exists
    assign g_sf_add = acc + sf_ext;
    assign g_sf_sub = acc - sf_ext;
    assign g_si_add = acc + si_ext;
    assign g_si_sub = acc - si_ext;
    assign g_ui_add = acc + ui_ext;
    assign g_ui_sub = acc - ui_ext;
    assign plain_smf = {mi.sf_hi, mi.sf_lo};
    assign w_hi_add = acc[63:32] + mi.sf_hi;
    assign w_lo_add = acc[31:0] + mi.sf_lo;
    assign w_hi_sub = acc[63:32] - mi.sf_hi;
    assign w_lo_sub = acc[31:0] - mi.sf_lo;
    // ************************************************************
    // result select
    // ************************************************************
    logic [63:0] next_result;
    logic next_acc_we;
    logic op_legal;
    always_comb begin
        next_result = 64'h0000_0000_0000_0000;
        next_acc_we = 1'b1;
        unique case (op)
            OP_GSMFAA: next_result = g_sf_add;
            OP_GSMFAN: next_result = g_sf_sub;
            OP_GSMIAA: next_result = g_si_add;
            OP_GSMIAN: next_result = g_si_sub;
            OP_GUMIAA: next_result = g_ui_add;
            OP_GUMIAN: next_result = g_ui_sub;
            OP_SMF: begin
                next_result = plain_smf;
                next_acc_we = acc_sel;
            end
            OP_SMFAAW: next_result = {w_hi_add, w_lo_add};
            OP_SMFANW: next_result = {w_hi_sub, w_lo_sub};
            default: next_acc_we = 1'b0;
        endcase
    end
    assign op_legal = (op != OP_NONE);
    // ************************************************************
    // state
    // ************************************************************
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc <= ACC_RESET;
        end else if (issue_valid_in && op_legal && next_acc_we) begin
            acc <= next_result;
        end
    end
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            result_valid_out <= 1'b0;
            result_out <= 64'h0000_0000_0000_0000;
            illegal_out <= 1'b0;
        end else begin
            result_valid_out <= issue_valid_in && op_legal;
            illegal_out <= issue_valid_in && !op_legal;
            if (issue_valid_in && op_legal) begin
                result_out <= next_result;
            end
        end
    end
    assign mac_accumulator_out = acc;
    // ************************************************************
    // assertions
    // ************************************************************
    property p_gsmfaa;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_GSMFAA) |=>
            result_out == $past(acc) + {{32{$past(mi.sf_lo[31])}},
                $past(mi.sf_lo)} && acc == result_out;
    endproperty
    a_gsmfaa: assert property (p_gsmfaa)
        else $error("fractional accumulate result wrong");
    property p_gsmfan;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_GSMFAN) |=>
            (result_out + {{32{$past(mi.sf_lo[31])}}, $past(mi.sf_lo)})
                == $past(acc);
    endproperty
    a_gsmfan: assert property (p_gsmfan)
        else $error("fractional negative result wrong");
    property p_wrap;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_GUMIAA && acc == 64'hFFFF_FFFF_FFFF_FFFF
            && mi.ui_lo == 32'h0000_0001) |=> acc == 64'h0000_0000_0000_0000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("unsigned sum did not wrap");
    property p_gsmian;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_GSMIAN) |=>
            result_out == $past(acc) - {{32{$past(mi.si_lo[31])}},
                $past(mi.si_lo)};
    endproperty
    a_gsmian: assert property (p_gsmian)
        else $error("signed integer negative result wrong");
    property p_gumian;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_GUMIAN) |=>
            result_out == $past(acc) - {32'h0000_0000, $past(mi.ui_lo)};
    endproperty
    a_gumian: assert property (p_gumian)
        else $error("unsigned negative result wrong");
    property p_acc_hold;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_SMF && !acc_sel) |=> $stable(acc);
    endproperty
    a_acc_hold: assert property (p_acc_hold)
        else $error("accumulator changed with select clear");
    property p_acc_copy;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_SMF && acc_sel) |=>
            acc == result_out && result_valid_out;
    endproperty
    a_acc_copy: assert property (p_acc_copy)
        else $error("accumulator not loaded with select set");
    property p_words;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_SMFAAW) |=>
            result_out[31:0] == $past(acc[31:0]) + $past(mi.sf_lo)
            && result_out[63:32] == $past(acc[63:32]) + $past(mi.sf_hi);
    endproperty
    a_words: assert property (p_words)
        else $error("word accumulate result wrong");
    property p_frac;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (mi.a_lo == 16'h8000 && mi.b_lo == 16'h8000) |->
            mi.sf_lo == 32'h8000_0000;
    endproperty
    a_frac: assert property (p_frac)
        else $error("fractional corner product wrong");
    // ************************************************************
    // further result and hold checks
    // ************************************************************
    property p_gsmiaa;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_GSMIAA) |=>
            result_out == $past(acc) + {{32{$past(mi.si_lo[31])}},
                $past(mi.si_lo)} && acc == result_out;
    endproperty
    a_gsmiaa: assert property (p_gsmiaa)
        else $error("signed integer accumulate result wrong");
    property p_gumiaa;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_GUMIAA) |=>
            result_out == $past(acc) + {32'h0000_0000, $past(mi.ui_lo)};
    endproperty
    a_gumiaa: assert property (p_gumiaa)
        else $error("unsigned accumulate result wrong");
    property p_smf;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_SMF) |=>
            result_out == {$past(mi.sf_hi), $past(mi.sf_lo)};
    endproperty
    a_smf: assert property (p_smf)
        else $error("plain fractional multiply result wrong");
    property p_wrap_sub;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_GUMIAN && acc == 64'h0000_0000_0000_0000
            && mi.ui_lo == 32'h0000_0001) |=> acc == 64'hFFFF_FFFF_FFFF_FFFF;
    endproperty
    a_wrap_sub: assert property (p_wrap_sub)
        else $error("unsigned difference did not wrap");
    property p_words_neg;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op == OP_SMFANW) |=>
            result_out[31:0] == $past(acc[31:0]) - $past(mi.sf_lo)
            && result_out[63:32] == $past(acc[63:32]) - $past(mi.sf_hi)
            && acc == result_out;
    endproperty
    a_words_neg: assert property (p_words_neg)
        else $error("word negative accumulate result wrong");
    property p_refused;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && !op_legal) |=>
            illegal_out && !result_valid_out && $stable(acc)
            && $stable(result_out);
    endproperty
    a_refused: assert property (p_refused)
        else $error("unknown opcode changed state");
    property p_idle;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !issue_valid_in |=> !result_valid_out && !illegal_out
            && $stable(acc) && $stable(result_out);
    endproperty
    a_idle: assert property (p_idle)
        else $error("state changed without an issue");
    property p_acc_write;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (issue_valid_in && op_legal && op != OP_SMF) |=>
            result_valid_out && acc == result_out;
    endproperty
    a_acc_write: assert property (p_acc_write)
        else $error("accumulator and result differ after update");
    property p_frac_hi;
        @(posedge core_clk_in) disable iff (!rstn_in)
        (mi.a_hi == 16'h8000 && mi.b_hi == 16'h8000) |->
            mi.sf_hi == 32'h8000_0000;
    endproperty
    a_frac_hi: assert property (p_frac_hi)
        else $error("upper fractional corner product wrong");
    property p_excl;
        @(posedge core_clk_in) disable iff (!rstn_in)
        !(result_valid_out && illegal_out);
    endproperty
    a_excl: assert property (p_excl)
        else $error("result and illegal pulses together");
    c_gsmfaa: cover property (@(posedge core_clk_in)
        issue_valid_in && op == OP_GSMFAA);
    c_smf_acc: cover property (@(posedge core_clk_in)
        issue_valid_in && op == OP_SMF && acc_sel);
    c_anw: cover property (@(posedge core_clk_in)
        issue_valid_in && op == OP_SMFANW);
    c_illegal: cover property (@(posedge core_clk_in)
        issue_valid_in && !op_legal);
    c_wrap: cover property (@(posedge core_clk_in)
        issue_valid_in && op == OP_GUMIAA
        && acc == 64'hFFFF_FFFF_FFFF_FFFF);
endmodule : even_halfword_mac_unit
`default_nettype wire

// File: core/halfword_mult.sv
/*
 * half-word multipliers: signed fractional products for both even
 * lanes, signed and unsigned integer products for the low lane.
 * assumes operands are stable for the cycle; no state.
 */
`default_nettype none
module halfword_mult
    import mac_pkg::*;
(
    mac_issue_if.mult m
);
    logic signed [31:0] prod_hi;
    logic signed [31:0] prod_lo;
    assign prod_hi = $signed(m.a_hi) * $signed(m.b_hi);
    assign prod_lo = $signed(m.a_lo) * $signed(m.b_lo);
    // 1.15 x 1.15: shift left one, -1 x -1 wraps to 0x8000_0000
    assign m.sf_hi = {prod_hi[30:0], 1'b0};
    assign m.sf_lo = {prod_lo[30:0], 1'b0};
    assign m.si_lo = prod_lo;
    assign m.ui_lo = m.a_lo * m.b_lo;
endmodule : halfword_mult
`default_nettype wire

// File: core/mac_issue_if.sv
/*
 * operand carrier between the datapath top and its multiplier leaf.
 * assumes one clock domain; purely combinational signals.
 */
`default_nettype none
interface mac_issue_if;
    logic [15:0] a_hi;
    logic [15:0] b_hi;
    logic [15:0] a_lo;
    logic [15:0] b_lo;
    logic [31:0] sf_hi;
    logic [31:0] sf_lo;
    logic [31:0] si_lo;
    logic [31:0] ui_lo;
    modport core (output a_hi, b_hi, a_lo, b_lo,
                  input sf_hi, sf_lo, si_lo, ui_lo);
    modport mult (input a_hi, b_hi, a_lo, b_lo,
                  output sf_hi, sf_lo, si_lo, ui_lo);
endinterface : mac_issue_if
`default_nettype wire

// File: core/mac_pkg.sv
/*
 * constants for the even half-word multiply-accumulate datapath:
 * instruction field positions, opcode encodings, widths.
 * assumes lsb-0 bit numbering of the instruction word (bit 0 = lsb).
 */
`default_nettype none
package mac_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int DATA_W = 64;
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int INSN_W = 32;
    // ************************************************************
    // instruction fields (lsb-0 positions)
    // ************************************************************
    localparam int PRIM_HI = 31;
    localparam int PRIM_LO = 26;
    localparam int EXT_HI = 10;
    localparam int EXT_LO = 0;
    localparam int ACC_SEL_POS = 5;
    // ************************************************************
    // operand half-word positions (lsb-0)
    // ************************************************************
    localparam int HI_EVEN_LO = 48;
    localparam int LO_EVEN_LO = 16;
    // ************************************************************
    // opcodes
    // ************************************************************
    localparam logic [5:0] PRIM_VEC = 6'h04;
    localparam logic [10:0] EXT_GSMFAA = 11'h52B;
    localparam logic [10:0] EXT_GSMFAN = 11'h5AB;
    localparam logic [10:0] EXT_GSMIAA = 11'h529;
    localparam logic [10:0] EXT_GSMIAN = 11'h5A9;
    localparam logic [10:0] EXT_GUMIAA = 11'h528;
    localparam logic [10:0] EXT_GUMIAN = 11'h5A8;
    localparam logic [10:0] EXT_SMF_MASK = 11'h7DF;
    localparam logic [10:0] EXT_SMF = 11'h40B;
    localparam logic [10:0] EXT_SMFAAW = 11'h50B;
    localparam logic [10:0] EXT_SMFANW = 11'h58B;
    localparam logic [63:0] ACC_RESET = 64'h0000_0000_0000_0000;
    typedef enum logic [3:0] {
        OP_NONE, OP_GSMFAA, OP_GSMFAN, OP_GSMIAA, OP_GSMIAN,
        OP_GUMIAA, OP_GUMIAN, OP_SMF, OP_SMFAAW, OP_SMFANW
    } mac_op_t;
endpackage : mac_pkg
`default_nettype wire

// File: sim/even_halfword_mac_unit_tb.sv
/*
 * bench for the even half-word multiply datapath: random issue stream
 * checked against a behavioural model at every cycle.
 * assumes issue_model drives the issue port.
 */
`default_nettype none
module even_halfword_mac_unit_tb
    import mac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic req = 1'b0;
    logic [31:0] insn_req = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_0002;
    logic [31:0] r;
    logic [63:0] a_req = 64'h0000_0000_0000_0000;
    logic [63:0] b_req = 64'h0000_0000_0000_0000;
    logic issue_valid, result_valid, illegal;
    logic [31:0] insn;
    logic [63:0] src_a, src_b, result, acc_seen;
    logic [63:0] m_acc = 64'h0000_0000_0000_0000;
    logic [63:0] m_res = 64'h0000_0000_0000_0000;
    logic m_v = 1'b0;
    logic m_ill = 1'b0;
    int errors = 0;
    int n_tests = 0;
    logic [10:0] codes [11] = '{EXT_GSMFAA, EXT_GSMFAN, EXT_GSMIAA,
        EXT_GSMIAN, EXT_GUMIAA, EXT_GUMIAN, EXT_SMF, EXT_SMF | 11'h020,
        EXT_SMFAAW, EXT_SMFANW, 11'h52C};
    always #10 core_clk_in = ~core_clk_in;
    issue_model drv (.core_clk_in(core_clk_in), .req_in(req),
        .insn_req_in(insn_req), .a_req_in(a_req), .b_req_in(b_req),
        .issue_valid_out(issue_valid), .insn_out(insn),
        .source_reg_a_out(src_a), .source_reg_b_out(src_b));
    even_halfword_mac_unit uut (.core_clk_in(core_clk_in),
        .rstn_in(rstn_in), .issue_valid_in(issue_valid), .insn_in(insn),
        .source_reg_a_in(src_a), .source_reg_b_in(src_b),
        .result_valid_out(result_valid), .result_out(result),
        .mac_accumulator_out(acc_seen), .illegal_out(illegal));
    // ************************************************************
    // helpers
    // ************************************************************
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function logic [63:0] opnd();
        logic [63:0] v;
        v = {rnd(), rnd()};
        if (v[34:33] == 2'h0) begin
            v[63:48] = 16'h8000;
            v[31:16] = 16'h8000;
        end else if (v[34:33] == 2'h1) begin
            v[63:48] = 16'hffff;
            v[31:16] = 16'hffff;
        end
        return v;
    endfunction : opnd
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task issue_op(input logic [10:0] code, input logic [15:0] lo);
        @(negedge core_clk_in);
        req = 1'b1;
        insn_req = {PRIM_VEC, 15'h0000, code};
        a_req = {32'h0000_0000, lo, 16'h0000};
        b_req = {32'h0000_0000, lo, 16'h0000};
    endtask : issue_op
    task tally_and_finish();
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // ************************************************************
    // reference model
    // ************************************************************
    always @(posedge core_clk_in) begin : model
        logic signed [31:0] sh, sl;
        logic [31:0] fh, fl, ul;
        sh = $signed({{16{src_a[63]}}, src_a[63:48]})
            * $signed({{16{src_b[63]}}, src_b[63:48]});
        sl = $signed({{16{src_a[31]}}, src_a[31:16]})
            * $signed({{16{src_b[31]}}, src_b[31:16]});
        fh = {sh[30:0], 1'b0};
        fl = {sl[30:0], 1'b0};
        ul = {16'h0000, src_a[31:16]} * {16'h0000, src_b[31:16]};
        m_v = 1'b0;
        m_ill = 1'b0;
        if (!rstn_in) begin
            m_acc = ACC_RESET;
            m_res = 64'h0000_0000_0000_0000;
        end else if (issue_valid) begin
            m_v = 1'b1;
            case ({insn[31:26] == PRIM_VEC, insn[10:0]})
                {1'b1, EXT_GSMFAA}: m_res = m_acc + {{32{fl[31]}}, fl};
                {1'b1, EXT_GSMFAN}: m_res = m_acc - {{32{fl[31]}}, fl};
                {1'b1, EXT_GSMIAA}: m_res = m_acc + {{32{sl[31]}}, sl};
                {1'b1, EXT_GSMIAN}: m_res = m_acc - {{32{sl[31]}}, sl};
                {1'b1, EXT_GUMIAA}: m_res = m_acc + {32'h0000_0000, ul};
                {1'b1, EXT_GUMIAN}: m_res = m_acc - {32'h0000_0000, ul};
                {1'b1, EXT_SMF}, {1'b1, EXT_SMF | 11'h020}: m_res = {fh, fl};
                {1'b1, EXT_SMFAAW}: m_res = {m_acc[63:32] + fh, m_acc[31:0] + fl};
                {1'b1, EXT_SMFANW}: m_res = {m_acc[63:32] - fh, m_acc[31:0] - fl};
                default: begin
                    m_v = 1'b0;
                    m_ill = 1'b1;
                end
            endcase
            if (m_v && insn[10:0] != EXT_SMF) m_acc = m_res;
        end
    end
    always @(negedge core_clk_in) begin
        if (!rstn_in) begin
            m_acc = ACC_RESET;
            m_res = 64'h0000_0000_0000_0000;
            m_v = 1'b0;
            m_ill = 1'b0;
        end
        chk("result_valid", {63'h0, m_v}, {63'h0, result_valid});
        chk("illegal", {63'h0, m_ill}, {63'h0, illegal});
        chk("result", m_res, result);
        chk("accumulator", m_acc, acc_seen);
    end
    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        repeat (12) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        issue_op(EXT_GUMIAN, 16'h0001);
        issue_op(EXT_GUMIAA, 16'h0001);
        for (int i = 0; i < 600; i++) begin
            @(negedge core_clk_in);
            r = rnd();
            req = r[1:0] != 2'h0;
            insn_req = {r[31:28] == 4'h0 ? 6'h05 : PRIM_VEC, r[25:11],
                codes[r[9:2] % 11]};
            a_req = opnd();
            b_req = opnd();
            if (i == 300) begin
                @(posedge core_clk_in);
                rstn_in <= 1'b0;
                @(negedge core_clk_in);
                req = 1'b0;
                repeat (3) @(posedge core_clk_in);
                rstn_in <= 1'b1;
            end
        end
        repeat (3) @(posedge core_clk_in);
        tally_and_finish();
    end
    initial begin
        #40000;
        errors++;
        tally_and_finish();
    end
endmodule : even_halfword_mac_unit_tb
`default_nettype wire

// File: sim/issue_model.sv
/*
 * pipeline-side issue model: presents instruction and both source
 * registers for one cycle when the bench asks.
 * assumes the bench sets its request lines away from the rising edge.
 */
`default_nettype none
module issue_model (
    // clock
    input wire logic core_clk_in,
    // request from the bench
    input wire logic req_in,
    input wire logic [31:0] insn_req_in,
    input wire logic [63:0] a_req_in,
    input wire logic [63:0] b_req_in,
    // issue port
    output logic issue_valid_out,
    output logic [31:0] insn_out,
    output logic [63:0] source_reg_a_out,
    output logic [63:0] source_reg_b_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        issue_valid_out = 1'b0;
        insn_out = 32'h0000_0000;
        source_reg_a_out = 64'h0000_0000_0000_0000;
        source_reg_b_out = 64'h0000_0000_0000_0000;
    end
    // instruction and both operands travel together, idle lines scramble
    always @(posedge core_clk_in) begin
        issue_valid_out <= req_in;
        if (req_in) begin
            insn_out <= insn_req_in;
            source_reg_a_out <= a_req_in;
            source_reg_b_out <= b_req_in;
        end else begin
            insn_out <= ~insn_out;
            source_reg_a_out <= ~source_reg_a_out;
            source_reg_b_out <= ~source_reg_b_out;
        end
    end
endmodule : issue_model
`default_nettype wire
